// ===== rtl/prf_pkg.sv
// Package: constants and types for the profile register and lock flag block
package prf_pkg;

   // ****************************************
   // Serial address map
   // ****************************************
   localparam logic [4:0] PRF_ADDR_CTRL_ONE = 5'h00;
   localparam logic [4:0] PRF_ADDR_PROF_SIX = 5'h0C;
   localparam logic [4:0] PRF_ADDR_PROF_SEV = 5'h0D;

   // ****************************************
   // Instruction byte fields
   // ****************************************
   localparam int         PRF_INSTR_RD_BIT  = 7;
   localparam int         PRF_INSTR_ADDR_HI = 4;

   // ****************************************
   // Register layout
   // ****************************************
   localparam int         PRF_PROF_W        = 64;
   localparam int         PRF_PROF_USED_W   = 62;
   localparam int         PRF_TUNE_W        = 48;
   localparam int         PRF_PHASE_W       = 14;
   localparam int         PRF_PHASE_LSB     = 48;
   localparam int         PRF_CTRL_W        = 32;
   localparam int         PRF_LOCK_FLAG_BIT = 24;

   // Last byte index of a transfer, bytes counted from zero
   localparam logic [2:0] PRF_PROF_LAST_BYTE = 3'h7;
   localparam logic [2:0] PRF_CTRL_LAST_BYTE = 3'h3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [61:0] PRF_PROF_RST = 62'h0000000000000000;
   localparam logic        PRF_FLAG_RST = 1'b0;

   // ****************************************
   // Transaction states
   // ****************************************
   typedef enum logic [1:0] {
      PRF_ST_INSTR = 2'b01,
      PRF_ST_DATA  = 2'b10
   } prf_state_t;

endpackage : prf_pkg

// ===== rtl/prf_ser_if.sv
// Interface: byte stream between serial shifter and register bank
`timescale 1ns/100ps
interface prf_ser_if;
   logic       frame_start;
   logic       rx_stb;
   logic [7:0] rx_byte;
   logic [7:0] tx_byte;
   logic       rd_active;

   modport ser  (output frame_start, output rx_stb, output rx_byte,
                 input tx_byte, input rd_active);
   modport regs (input frame_start, input rx_stb, input rx_byte,
                 output tx_byte, output rd_active);
endinterface : prf_ser_if

// ===== rtl/prf_ser.sv
// Module: serial port pin synchroniser and byte shifter
`timescale 1ns/100ps
module prf_ser (
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic sdi,
   output logic      sdo_bit,
   prf_ser_if.ser    bus
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   logic       sclk_d_ff;
   logic       cs_d_ff;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         meta_ff   <= 3'h3;
         sync_ff   <= 3'h3;
         sclk_d_ff <= 1'b1;
         cs_d_ff   <= 1'b1;
      end else begin
         meta_ff   <= {sdi, cs_n, sclk};
         sync_ff   <= meta_ff;
         sclk_d_ff <= sync_ff[0];
         cs_d_ff   <= sync_ff[1];
      end
   end

   logic sclk_s;
   logic cs_s_n;
   logic sdi_s;
   logic rise;
   logic fall;

   assign sclk_s = sync_ff[0];
   assign cs_s_n = sync_ff[1];
   assign sdi_s  = sync_ff[2];
   assign rise   = !cs_s_n && sclk_s && !sclk_d_ff;
   assign fall   = !cs_s_n && !sclk_s && sclk_d_ff;

   // ****************************************
   // Shifters
   // ****************************************
   logic [2:0] cnt_ff,  nxt_cnt;
   logic [7:0] in_ff,   nxt_in;
   logic [7:0] out_ff,  nxt_out;
   logic       stb_ff,  nxt_stb;

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_in  = in_ff;
      nxt_out = out_ff;
      nxt_stb = 1'b0;
      if (cs_s_n) begin
         nxt_cnt = 3'h0;
      end else begin
         if (rise) begin
            nxt_in  = {in_ff[6:0], sdi_s};
            nxt_cnt = cnt_ff + 3'h1;
            nxt_stb = (cnt_ff == 3'h7);
         end
         // Load on the first falling edge of a byte, so data is ready before its first rise
         if (fall) begin
            nxt_out = (cnt_ff == 3'h0) ? bus.tx_byte : {out_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= 3'h0;
         in_ff  <= 8'h00;
         out_ff <= 8'h00;
         stb_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         in_ff  <= nxt_in;
         out_ff <= nxt_out;
         stb_ff <= nxt_stb;
      end
   end

   assign bus.rx_stb      = stb_ff;
   assign bus.rx_byte     = in_ff;
   // Held through idle time too, so a read cut short still releases the data pin
   assign bus.frame_start = cs_s_n || cs_d_ff;
   assign sdo_bit         = out_ff[7];

endmodule : prf_ser

// ===== rtl/prf_regs.sv
// Module: profile six/seven registers and lock-loss flag behind the serial port
`timescale 1ns/100ps
module prf_regs (
   input  wire logic         clock,
   input  wire logic         arst_n,
   input  wire logic         sclk,
   input  wire logic         cs_n,
   input  wire logic         sdio_in,
   output logic              sdio_out,
   output logic              sdio_oe_n,
   output logic              sdo,
   input  wire logic         three_wire_mode,
   input  wire logic         auto_sync_mode,
   input  wire logic         hw_manual_sync_mode,
   input  wire logic         pll_locked,
   output logic              status_out,
   output logic              status_oe_n,
   output logic              lock_lost_flag,
   output logic [47:0]       profile_six_tuning_word,
   output logic [13:0]       profile_six_phase_offset,
   output logic [47:0]       profile_seven_tuning_word,
   output logic [13:0]       profile_seven_phase_offset
);

   // ****************************************
   // Serial shifter
   // ****************************************
   prf_ser_if sbus ();
   logic      sdo_bit;

   prf_ser u_ser (
      .clock   (clock),
      .arst_n  (arst_n),
      .sclk    (sclk),
      .cs_n    (cs_n),
      .sdi     (sdio_in),
      .sdo_bit (sdo_bit),
      .bus     (sbus.ser)
   );

   // ****************************************
   // Lock indicator synchroniser
   // ****************************************
   logic lock_meta_ff;
   logic lock_sync_ff;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_meta_ff <= 1'b1;
         lock_sync_ff <= 1'b1;
      end else begin
         lock_meta_ff <= pll_locked;
         lock_sync_ff <= lock_meta_ff;
      end
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [7:0] prf_byte_of(input logic [63:0] word, input logic [2:0] idx);
      logic [5:0] lsb;
      lsb = 6'(7 - idx) << 3;
      prf_byte_of = word[lsb +: 8];
   endfunction : prf_byte_of

   function automatic logic [61:0] prf_put_byte(input logic [61:0] word,
                                                input logic [2:0]  idx,
                                                input logic [7:0]  data);
      logic [63:0] full;
      logic [5:0]  lsb;
      full            = {2'b00, word};
      lsb             = 6'(7 - idx) << 3;
      full[lsb +: 8]  = data;
      prf_put_byte    = full[61:0];
   endfunction : prf_put_byte

   // ****************************************
   // Transaction state and registers
   // ****************************************
   prf_pkg::prf_state_t state_ff, nxt_state;
   logic [4:0]          addr_ff,  nxt_addr;
   logic                rd_ff,    nxt_rd;
   logic                valid_ff, nxt_valid;
   logic [2:0]          idx_ff,   nxt_idx;
   logic [2:0]          last_ff,  nxt_last;
   logic [7:0]          tx_ff,    nxt_tx;
   logic [61:0]         six_ff,   nxt_six;
   logic [61:0]         sev_ff,   nxt_sev;
   logic                flag_ff,  nxt_flag;

   logic [4:0]  instr_addr;
   logic        flag_clear;
   logic [63:0] ctrl_word;

   // Only the lock flag at bit 24 of the control word lives here; all other bits read zero
   assign ctrl_word = {32'h00000000, 7'h00, flag_ff, 24'h000000};

   function automatic logic [63:0] prf_read_word(input logic [4:0]  addr,
                                                 input logic [61:0] six,
                                                 input logic [61:0] sev,
                                                 input logic [63:0] ctrl);
      unique case (addr)
         prf_pkg::PRF_ADDR_PROF_SIX: prf_read_word = {2'b00, six};
         prf_pkg::PRF_ADDR_PROF_SEV: prf_read_word = {2'b00, sev};
         prf_pkg::PRF_ADDR_CTRL_ONE: prf_read_word = {ctrl[31:0], 32'h00000000};
         default:                    prf_read_word = 64'h0000000000000000;
      endcase
   endfunction : prf_read_word

   assign instr_addr = sbus.rx_byte[prf_pkg::PRF_INSTR_ADDR_HI:0];

   always_comb begin
      nxt_state  = state_ff;
      nxt_addr   = addr_ff;
      nxt_rd     = rd_ff;
      nxt_valid  = valid_ff;
      nxt_idx    = idx_ff;
      nxt_last   = last_ff;
      nxt_tx     = tx_ff;
      nxt_six    = six_ff;
      nxt_sev    = sev_ff;
      flag_clear = 1'b0;
      if (sbus.frame_start) begin
         nxt_state = prf_pkg::PRF_ST_INSTR;
         nxt_tx    = 8'h00;
      end else if (sbus.rx_stb) begin
         unique case (state_ff)
            prf_pkg::PRF_ST_INSTR: begin
               nxt_state = prf_pkg::PRF_ST_DATA;
               nxt_addr  = instr_addr;
               nxt_rd    = sbus.rx_byte[prf_pkg::PRF_INSTR_RD_BIT];
               nxt_idx   = 3'h0;
               nxt_valid = 1'b1;
               unique case (instr_addr)
                  prf_pkg::PRF_ADDR_PROF_SIX: nxt_last = prf_pkg::PRF_PROF_LAST_BYTE;
                  prf_pkg::PRF_ADDR_PROF_SEV: nxt_last = prf_pkg::PRF_PROF_LAST_BYTE;
                  // Whole four-byte word assumed on the control register
                  prf_pkg::PRF_ADDR_CTRL_ONE: nxt_last = prf_pkg::PRF_CTRL_LAST_BYTE;
                  default: begin
                     nxt_last  = 3'h0;
                     nxt_valid = 1'b0;
                  end
               endcase
               nxt_tx = nxt_rd ? prf_byte_of(prf_read_word(instr_addr, six_ff, sev_ff,
                                                           ctrl_word), 3'h0) : 8'h00;
               // Flag byte goes out first, so the readback clears it here
               flag_clear = nxt_rd && (instr_addr == prf_pkg::PRF_ADDR_CTRL_ONE);
            end
            prf_pkg::PRF_ST_DATA: begin
               if (valid_ff && !rd_ff) begin
                  if (addr_ff == prf_pkg::PRF_ADDR_PROF_SIX) begin
                     nxt_six = prf_put_byte(six_ff, idx_ff, sbus.rx_byte);
                  end
                  if (addr_ff == prf_pkg::PRF_ADDR_PROF_SEV) begin
                     nxt_sev = prf_put_byte(sev_ff, idx_ff, sbus.rx_byte);
                  end
               end
               nxt_idx = idx_ff + 3'h1;
               nxt_tx  = (rd_ff && valid_ff)
                       ? prf_byte_of(prf_read_word(addr_ff, six_ff, sev_ff, ctrl_word),
                                     nxt_idx)
                       : 8'h00;
               // Unknown addresses take one byte, then a new instruction is expected
               if (idx_ff == last_ff) begin
                  nxt_state = prf_pkg::PRF_ST_INSTR;
                  nxt_tx    = 8'h00;
               end
            end
         endcase
      end
   end

   // Unlock level sets; set beats the readback clear
   always_comb begin
      nxt_flag = flag_ff;
      if (flag_clear) begin
         nxt_flag = 1'b0;
      end
      if (!lock_sync_ff) begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= prf_pkg::PRF_ST_INSTR;
         addr_ff  <= 5'h00;
         rd_ff    <= 1'b0;
         valid_ff <= 1'b0;
         idx_ff   <= 3'h0;
         last_ff  <= 3'h0;
         tx_ff    <= 8'h00;
         six_ff   <= prf_pkg::PRF_PROF_RST;
         sev_ff   <= prf_pkg::PRF_PROF_RST;
         flag_ff  <= prf_pkg::PRF_FLAG_RST;
      end else begin
         state_ff <= nxt_state;
         addr_ff  <= nxt_addr;
         rd_ff    <= nxt_rd;
         valid_ff <= nxt_valid;
         idx_ff   <= nxt_idx;
         last_ff  <= nxt_last;
         tx_ff    <= nxt_tx;
         six_ff   <= nxt_six;
         sev_ff   <= nxt_sev;
         flag_ff  <= nxt_flag;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic sync_mode;

   assign sbus.tx_byte  = tx_ff;
   assign sbus.rd_active = (state_ff == prf_pkg::PRF_ST_DATA) && rd_ff;

   assign sdo       = sdo_bit;
   assign sdio_out  = sdo_bit;
   assign sdio_oe_n = !(sbus.rd_active && !three_wire_mode);

   // Pin becomes the sync input; flag carries the lock news instead
   assign sync_mode   = auto_sync_mode || hw_manual_sync_mode;
   assign status_oe_n = sync_mode;
   assign status_out  = sync_mode ? 1'b0 : lock_sync_ff;
   assign lock_lost_flag = flag_ff;

   assign profile_six_tuning_word    = six_ff[prf_pkg::PRF_TUNE_W-1:0];
   assign profile_six_phase_offset   = six_ff[prf_pkg::PRF_PHASE_LSB +: prf_pkg::PRF_PHASE_W];
   assign profile_seven_tuning_word  = sev_ff[prf_pkg::PRF_TUNE_W-1:0];
   assign profile_seven_phase_offset = sev_ff[prf_pkg::PRF_PHASE_LSB +: prf_pkg::PRF_PHASE_W];

endmodule : prf_regs

// ===== tb/prf_host.sv
// Partner model: host controller on the serial control port
`timescale 1ns/100ps
module prf_host (
   input  wire logic clock,
   input  wire logic rd_line,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi
);
   // Twice the sampler minimum, so pin timing is never marginal
   localparam int HALF = 8;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   task automatic frame_begin();
      @(posedge clock);
      cs_n <= 1'b0;
      repeat (HALF) @(posedge clock);
   endtask : frame_begin
   task automatic frame_end();
      repeat (HALF) @(posedge clock);
      cs_n <= 1'b1;
      sdi  <= ~sdi;
      repeat (HALF) @(posedge clock);
   endtask : frame_end
   // Listening: line toggles, so a silent device reads as garbage
   task automatic xfer(input logic [7:0] tx, input bit lsn, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk <= 1'b0;
         sdi  <= lsn ? ~sdi : tx[i];
         repeat (HALF) @(posedge clock);
         sclk <= 1'b1;
         rx[i] = rd_line;
         repeat (HALF) @(posedge clock);
      end
   endtask : xfer
   task automatic access(input logic [4:0] a, input bit rd, input int nb,
                         input logic [63:0] wr, output logic [63:0] got);
      logic [7:0]  b;
      logic [63:0] w;
      int          n;
      n = (a == 5'h00) ? 4 : nb;
      w = (n == 4) ? (wr & 64'h01FF_FFFF) : (wr & 64'h3FFF_FFFF_FFFF_FFFF);
      got = '0;
      xfer({rd, 2'h0, a}, 1'b0, b);
      for (int k = n - 1; k >= 0; k--) begin
         xfer(w[k*8 +: 8], rd, b);
         got[k*8 +: 8] = b;
      end
   endtask : access
endmodule : prf_host

// ===== tb/prf_regs_monitor.sv
// Checker: port assertions for the profile registers and lock flag
`timescale 1ns/100ps
module prf_regs_monitor (
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic        cs_n,
   input wire logic        pll_locked,
   input wire logic        auto_sync_mode,
   input wire logic        hw_manual_sync_mode,
   input wire logic        sdio_oe_n,
   input wire logic        status_out,
   input wire logic        status_oe_n,
   input wire logic        lock_lost_flag,
   input wire logic [47:0] profile_six_tuning_word,
   input wire logic [13:0] profile_six_phase_offset,
   input wire logic [47:0] profile_seven_tuning_word,
   input wire logic [13:0] profile_seven_phase_offset
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   flag_hold_a: assert property (lock_lost_flag && cs_n |=> lock_lost_flag)
      else $error("flag fell outside a frame");
   flag_set_a: assert property (!pll_locked [*6] |-> lock_lost_flag)
      else $error("unlock did not set flag");
   flag_cause_a: assert property ($rose(lock_lost_flag) |-> !$past(pll_locked, 3))
      else $error("flag rose without unlock");
   flag_clear_a: assert property ($fell(lock_lost_flag) |->
      !cs_n && $past(pll_locked, 3))
      else $error("flag cleared without readback");
   status_free_a: assert property ((auto_sync_mode || hw_manual_sync_mode) [*3]
      |-> status_oe_n && !status_out)
      else $error("status pin driven in sync mode");
   status_drive_a: assert property ((!auto_sync_mode && !hw_manual_sync_mode
      && pll_locked) [*4] |-> !status_oe_n && status_out)
      else $error("status pin not showing lock");
   prof_hold_a: assert property (cs_n [*8] |-> $stable({profile_six_tuning_word,
      profile_six_phase_offset, profile_seven_tuning_word, profile_seven_phase_offset}))
      else $error("profile changed outside a frame");
   sdio_idle_a: assert property (cs_n [*8] |-> sdio_oe_n)
      else $error("data pin driven outside a frame");
endmodule : prf_regs_monitor

// ===== tb/testbench.sv
// Testbench: scenarios for the profile registers and lock flag
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
   logic        clock, arst_n, three_wire_mode, auto_sync_mode, hw_manual_sync_mode;
   logic        pll_locked, sclk, cs_n, host_sdi, sdio_out, sdio_oe_n, sdo;
   logic        status_out, status_oe_n, lock_lost_flag;
   logic [47:0] six_tw, sev_tw;
   logic [13:0] six_po, sev_po;
   logic [63:0] got;
   int          mismatches, checks;
   // Two-way pin: the device wins only while it enables
   wire         sdio_line = sdio_oe_n ? host_sdi : sdio_out;
   wire         rd_line   = three_wire_mode ? sdo : sdio_line;
   prf_host i_prf_host (.clock, .rd_line, .sclk, .cs_n, .sdi(host_sdi));
   prf_regs i_prf_regs (.clock, .arst_n, .sclk, .cs_n, .sdio_in(sdio_line), .sdio_out,
      .sdio_oe_n, .sdo, .three_wire_mode, .auto_sync_mode, .hw_manual_sync_mode,
      .pll_locked, .status_out, .status_oe_n, .lock_lost_flag,
      .profile_six_tuning_word(six_tw), .profile_six_phase_offset(six_po),
      .profile_seven_tuning_word(sev_tw), .profile_seven_phase_offset(sev_po));
   always #2.5 clock = ~clock;
   task automatic final_report();
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   task automatic wait_flag();
      int n;
      n = 0;
      while (lock_lost_flag !== 1'b1 && n < 20) begin
         @(posedge clock);
         n++;
      end
      if (n >= 20) begin
         mismatches++;
         final_report();
      end
   endtask : wait_flag
   task automatic xs(input logic [4:0] a, input bit rd, input int nb, input logic [63:0] v);
      i_prf_host.frame_begin();
      i_prf_host.access(a, rd, nb, v, got);
      i_prf_host.frame_end();
   endtask : xs
   task automatic t_reset();
      `CHK({six_po, six_tw, sev_po, sev_tw}, 124'h0)
      `CHK(lock_lost_flag, 1'b0)
      i_prf_host.frame_begin();
      i_prf_host.access(5'h0C, 1'b1, 8, 64'h0, got);
      `CHK(got, 64'h0)
      i_prf_host.access(5'h0D, 1'b1, 8, 64'h0, got);
      `CHK(got, 64'h0)
      i_prf_host.frame_end();
      $display("test reset done");
   endtask : t_reset
   task automatic t_profiles();
      i_prf_host.frame_begin();
      i_prf_host.access(5'h0C, 1'b0, 8, 64'h2ABC_DEF0_1234_5678, got);
      i_prf_host.access(5'h0D, 1'b0, 8, 64'hFFFF_FFFF_FFFF_FFFF, got);
      i_prf_host.frame_end();
      `CHK({six_po, six_tw}, 62'h2ABC_DEF0_1234_5678)
      `CHK({sev_po, sev_tw}, 62'h3FFF_FFFF_FFFF_FFFF)
      // Abort after three bytes: those bytes stay written
      // Host sends the low bytes of a short value
      xs(5'h0C, 1'b0, 3, 64'h0000_0000_0011_1122);
      `CHK({six_po, six_tw}, 62'h1111_22F0_1234_5678)
      xs(5'h0C, 1'b1, 8, 64'h0);
      `CHK(got, 64'h1111_22F0_1234_5678)
      // Read cut after two bytes must leave the data pin released
      xs(5'h0C, 1'b1, 2, 64'h0);
      `CHK(got, 64'h1111)
      `CHK(sdio_oe_n, 1'b1)
      xs(5'h0D, 1'b1, 8, 64'h0);
      `CHK(got, 64'h3FFF_FFFF_FFFF_FFFF)
      $display("test profiles done");
   endtask : t_profiles
   task automatic t_flag();
      three_wire_mode <= 1'b1;
      pll_locked <= 1'b0;
      wait_flag();
      pll_locked <= 1'b1;
      repeat (20) @(posedge clock);
      `CHK(lock_lost_flag, 1'b1)
      xs(5'h00, 1'b0, 4, 64'h0);
      `CHK(lock_lost_flag, 1'b1)
      xs(5'h00, 1'b1, 4, 64'h0);
      `CHK(got, 64'h0100_0000)
      `CHK(lock_lost_flag, 1'b0)
      xs(5'h00, 1'b1, 4, 64'h0);
      `CHK(got, 64'h0)
      pll_locked <= 1'b0;
      wait_flag();
      xs(5'h00, 1'b1, 4, 64'h0);
      `CHK(lock_lost_flag, 1'b1)
      pll_locked <= 1'b1;
      xs(5'h00, 1'b1, 4, 64'h0);
      `CHK(got, 64'h0100_0000)
      $display("test flag done");
   endtask : t_flag
   task automatic t_modes();
      logic [1:0] m;
      `CHK({status_oe_n, status_out}, 2'b01)
      for (int i = 1; i < 3; i++) begin
         m = 2'(i);
         auto_sync_mode <= m[0];
         hw_manual_sync_mode <= m[1];
         pll_locked <= 1'b0;
         wait_flag();
         `CHK({status_oe_n, status_out}, 2'b10)
         pll_locked <= 1'b1;
         xs(5'h00, 1'b1, 4, 64'h0);
         `CHK(got, 64'h0100_0000)
      end
      auto_sync_mode <= 1'b0;
      hw_manual_sync_mode <= 1'b0;
      pll_locked <= 1'b0;
      repeat (6) @(posedge clock);
      `CHK({status_oe_n, status_out}, 2'b00)
      $display("test modes done");
   endtask : t_modes
   initial begin
      clock = 1'b0;
      arst_n = 1'b0;
      three_wire_mode = 1'b0;
      auto_sync_mode = 1'b0;
      hw_manual_sync_mode = 1'b0;
      pll_locked = 1'b1;
      mismatches = 0;
      checks = 0;
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      t_reset();
      t_profiles();
      t_flag();
      t_modes();
      final_report();
   end
   initial begin
      repeat (100000) @(posedge clock);
      mismatches++;
      final_report();
   end
endmodule : testbench
bind prf_regs prf_regs_monitor i_prf_regs_monitor (.clock, .arst_n, .cs_n, .pll_locked,
   .auto_sync_mode, .hw_manual_sync_mode, .sdio_oe_n, .status_out, .status_oe_n,
   .lock_lost_flag, .profile_six_tuning_word, .profile_six_phase_offset,
   .profile_seven_tuning_word, .profile_seven_phase_offset);
